// *** ocu_compare_unit.sv ***
// Output compare channel of a 16-bit timer/counter
//
// Summary of operation
// - Compare full 16-bit count with compare value on every timer clock pulse.
// - Match flag is set one timer clock after the match.
// - Enabled flag requests interrupt; cleared on service or by writing one.
// - Output state from match, mode, action bits, TOP and BOTTOM.
// - Channel A active compare value may act as counter TOP.
// - Compare value double buffered in all twelve PWM modes only.
// - Buffered value moves to active register only at TOP or BOTTOM.
// - CPU reaches buffer when buffering, else active register directly.
// - Only CPU writes change compare value; high byte read is direct.
// - High byte goes to holding register; low write loads all 16 bits.
// - Non-PWM force strobe acts like match, no flag, no counter effect.
// - Counter write blocks any match in the following timer clock.
// - Counter written equal to variable TOP loses the TOP match.
// - Output state holds across waveform mode changes.
// - Action bits unbuffered; take effect at next match or force.
// - System reset clears the output state to zero.
// - Nonzero action overrides port data on pin; direction bit still rules.
// - Action zero leaves the output state unchanged on a match.
// - Action bits have no influence on input capture.
`timescale 1ns/1ns
module ocu_compare_unit
    import ocu_pkg::*;
#(
    parameter int CNT_W = OCU_CNT_W
) (
    // Clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    // Counter status from the timer core
    input  wire ocu_cnt_stat_t       cnt_stat_in,
    input  wire logic                count_write_in,
    // CPU side of the compare value
    input  wire ocu_cpu_wr_t         cpu_wr_in,
    input  wire logic                read_high_in,
    // Control bits
    input  wire logic [3:0]          waveform_select_in,
    input  wire logic [1:0]          compare_output_action_in,
    input  wire logic                force_compare_strobe_in,
    input  wire logic                compare_irq_enable_in,
    input  wire logic                flag_clear_write_in,
    input  wire logic                irq_ack_in,
    // Port pin controls
    input  wire logic                port_data_in,
    input  wire logic                output_pin_direction_bit_in,
    // Status and results
    output logic                     compare_match_flag_out,
    output logic                     irq_req_out,
    output logic                     match_out,
    output logic                     compare_output_state_out,
    output logic [CNT_W-1:0]         compare_value_reg_out,
    output logic [OCU_BYTE_W-1:0]    read_data_out,
    // Output pin
    output logic                     pin_out,
    output logic                     pin_oe_out
);

    // Registers
    logic [CNT_W-1:0]      active_q;
    logic [CNT_W-1:0]      buffer_q;
    logic [OCU_BYTE_W-1:0] temp_q;
    logic                  pend_flag_q;
    logic                  flag_q;
    logic                  flag_d;
    logic                  irq_q;
    logic                  match_q;
    logic                  state_q;
    logic                  state_d;
    logic                  down_q;
    logic                  pin_q;
    logic                  pin_oe_q;
    logic [OCU_BYTE_W-1:0] rd_q;

    // Decoded mode and events
    logic             pwm_mode;
    logic             fast_mode;
    logic             match;
    logic             reload;
    logic             force_hit;
    logic [CNT_W-1:0] cpu_word;
    logic [CNT_W-1:0] visible;

    // Mode decode shared by buffering, force and waveform logic
    assign pwm_mode  = ocu_is_pwm(waveform_select_in);
    assign fast_mode = ocu_is_fast(waveform_select_in);

    // The block sits beside the comparator so a counter write made while
    // the timer clock is stopped is still spent on the next pulse
    // 16-bit compare
    ocu_match_detect #(
        .WIDTH          (CNT_W)
    ) u_match (
        .sys_clk_in     (sys_clk_in),
        .sys_rst_in     (sys_rst_in),
        .count_in       (cnt_stat_in.count),
        .compare_in     (active_q),
        .tick_in        (cnt_stat_in.tick),
        .count_write_in (count_write_in),
        .equal_out      (),
        .match_out      (match)
    );

    assign cpu_word = {temp_q, cpu_wr_in.data};

    // Qualified by the tick so a TOP or BOTTOM level held between timer
    // pulses cannot copy the buffer more than once
    // reload point per mode
    assign reload = cnt_stat_in.tick &&
                    (ocu_load_at_bottom(waveform_select_in) ?
                     cnt_stat_in.bottom : cnt_stat_in.top);

    // A forced match in PWM would break the period, so it is ignored
    // force only outside PWM
    assign force_hit = force_compare_strobe_in && !pwm_mode;

    // A low write without a fresh high byte reuses the old one, so
    // software must always write the high byte first
    // holding register for the high byte
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            temp_q <= OCU_TEMP_RESET;
        end else if (cpu_wr_in.wr_high) begin
            temp_q <= cpu_wr_in.data;
        end
    end

    // Buffer register, written by the CPU only while buffering is on
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            buffer_q <= OCU_CMP_RESET;
        end else if (cpu_wr_in.wr_low && pwm_mode) begin
            buffer_q <= cpu_word;
        end
    end

    // Active compare register; the timer never writes it on its own.
    // A CPU write in the same cycle as a reload is taken by the buffer,
    // so the reload still moves the previous buffered value.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            active_q <= OCU_CMP_RESET;
        end else if (cpu_wr_in.wr_low && !pwm_mode) begin
            active_q <= cpu_word;
        end else if (pwm_mode && reload) begin
            active_q <= buffer_q;
        end
    end

    // Registered match, also the TOP indication for channel A.
    // active value as counter TOP
    // blocked TOP match is not reported
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // The pending bit holds a match until the next pulse, so a stopped
    // timer clock also holds back the flag
    // flag one timer clock late
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pend_flag_q <= 1'b0;
        end else if (cnt_stat_in.tick) begin
            pend_flag_q <= match;
        end
    end

    always_comb begin
        flag_d = flag_q;
        if (flag_clear_write_in || (irq_ack_in && irq_q)) begin
            flag_d = 1'b0;
        end
        if (cnt_stat_in.tick && pend_flag_q) begin
            flag_d = 1'b1;
        end
    end

    // Flag and interrupt request registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q  <= flag_d && compare_irq_enable_in;
        end
    end

    // Count direction for dual-slope modes, learned from TOP and BOTTOM.
    // Limitation: after reset the count is taken as rising until the
    // first TOP pulse is seen.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            down_q <= 1'b0;
        end else if (cnt_stat_in.tick && cnt_stat_in.top) begin
            down_q <= 1'b1;
        end else if (cnt_stat_in.tick && cnt_stat_in.bottom) begin
            down_q <= 1'b0;
        end
    end

    // Next output state. Action bits are read live, so a new setting
    // applies at the very next match or force with no buffering.
    // waveform generator
    always_comb begin
        state_d = state_q;
        if (!pwm_mode) begin
            if (match || force_hit) begin
                case (compare_output_action_in)
                    OCU_ACT_TOGGLE: state_d = !state_q;
                    OCU_ACT_CLEAR:  state_d = 1'b0;
                    OCU_ACT_SET:    state_d = 1'b1;
                    default:        state_d = state_q;
                endcase
            end
        end else if (compare_output_action_in[1]) begin
            // PWM: bit 0 of the action selects the inverted waveform
            if (fast_mode) begin
                if (match) begin
                    state_d = !compare_output_action_in[0];
                end else if (cnt_stat_in.tick && cnt_stat_in.top) begin
                    state_d = compare_output_action_in[0];
                end
            end else if (match) begin
                // Dual slope: level depends on the counting direction
                state_d = down_q ^ compare_output_action_in[0];
            end
        end
    end

    // Output compare state; no reset on mode change
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_q <= OCU_STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Pin driver. The next state is used so the pin follows the state
    // register in the same cycle rather than one cycle behind it.
    // Direction comes straight from the port bit; the action bits never
    // decide whether the pin drives.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_q    <= (compare_output_action_in != OCU_ACT_NONE) ?
                        state_d : port_data_in;
            pin_oe_q <= output_pin_direction_bit_in;
        end
    end

    // direct read of the visible register, no holding register
    assign visible = pwm_mode ? buffer_q : active_q;

    // Read data; the action bits feed nothing on the capture side.
    // There is no capture path in this block, so the action bits reach
    // only the waveform logic and the pin mux.
    // no capture influence
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rd_q <= OCU_TEMP_RESET;
        end else if (read_high_in) begin
            rd_q <= visible[CNT_W-1 -: OCU_BYTE_W];
        end else begin
            rd_q <= visible[OCU_BYTE_W-1:0];
        end
    end

    // Outputs straight from flip-flops
    // No output has a combinational path from an input
    assign compare_match_flag_out   = flag_q;
    assign irq_req_out              = irq_q;
    assign match_out                = match_q;
    assign compare_output_state_out = state_q;
    assign compare_value_reg_out    = active_q;
    assign read_data_out            = rd_q;
    assign pin_out                  = pin_q;
    assign pin_oe_out               = pin_oe_q;

endmodule

// *** ocu_pkg.sv ***
// Constants, types and mode helpers for the timer output compare unit
package ocu_pkg;

    // Widths
    localparam int OCU_CNT_W = 16;
    localparam int OCU_BYTE_W = 8;

    // Reset values
    localparam logic [15:0] OCU_CMP_RESET   = 16'h0000;
    localparam logic [7:0]  OCU_TEMP_RESET  = 8'h00;
    localparam logic        OCU_STATE_RESET = 1'b0;

    // Compare output action encodings
    localparam logic [1:0] OCU_ACT_NONE   = 2'h0;
    localparam logic [1:0] OCU_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] OCU_ACT_CLEAR  = 2'h2;
    localparam logic [1:0] OCU_ACT_SET    = 2'h3;

    // Waveform select codes that need special handling
    localparam logic [3:0] OCU_WGM_NORMAL   = 4'h0;
    localparam logic [3:0] OCU_WGM_CTC_A    = 4'h4;
    localparam logic [3:0] OCU_WGM_CTC_CAP  = 4'hc;
    localparam logic [3:0] OCU_WGM_RESERVED = 4'hd;
    localparam logic [3:0] OCU_WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] OCU_WGM_PFC_A    = 4'h9;
    localparam logic [3:0] OCU_WGM_FAST_8   = 4'h5;
    localparam logic [3:0] OCU_WGM_FAST_9   = 4'h6;
    localparam logic [3:0] OCU_WGM_FAST_10  = 4'h7;
    localparam logic [3:0] OCU_WGM_FAST_CAP = 4'he;
    localparam logic [3:0] OCU_WGM_FAST_A   = 4'hf;

    // CPU byte write strobes with their data
    typedef struct packed {
        logic       wr_high;
        logic       wr_low;
        logic [7:0] data;
    } ocu_cpu_wr_t;

    // Counter status seen by the compare unit
    typedef struct packed {
        logic        tick;
        logic        top;
        logic        bottom;
        logic [15:0] count;
    } ocu_cnt_stat_t;

    // Non-PWM modes are Normal, both clear-on-match modes and the reserved code
    function automatic logic ocu_is_pwm(input logic [3:0] wgm);
        ocu_is_pwm = !(wgm == OCU_WGM_NORMAL || wgm == OCU_WGM_CTC_A ||
                       wgm == OCU_WGM_CTC_CAP || wgm == OCU_WGM_RESERVED);
    endfunction

    // Single-slope PWM modes
    function automatic logic ocu_is_fast(input logic [3:0] wgm);
        ocu_is_fast = (wgm == OCU_WGM_FAST_8) || (wgm == OCU_WGM_FAST_9) ||
                      (wgm == OCU_WGM_FAST_10) ||
                      (wgm == OCU_WGM_FAST_CAP) || (wgm == OCU_WGM_FAST_A);
    endfunction

    // Phase and frequency correct modes reload at BOTTOM, the rest at TOP
    function automatic logic ocu_load_at_bottom(input logic [3:0] wgm);
        ocu_load_at_bottom = (wgm == OCU_WGM_PFC_CAP) ||
                             (wgm == OCU_WGM_PFC_A);
    endfunction

endpackage

// *** ocu_match_detect.sv ***
// Equality comparator with match blocking after a counter write
`timescale 1ns/1ns
module ocu_match_detect #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             sys_rst_in,
    // Compare operands
    input  wire logic [WIDTH-1:0] count_in,
    input  wire logic [WIDTH-1:0] compare_in,
    // Timer clock pulse and counter write strobe
    input  wire logic             tick_in,
    input  wire logic             count_write_in,
    // Results
    output logic                  equal_out,
    output logic                  match_out
);

    logic block_q;

    // Continuous full-width equality
    assign equal_out = (count_in == compare_in);

    // A match only counts on a timer clock pulse that is not blocked
    assign match_out = tick_in && equal_out && !block_q && !count_write_in;

    // Block armed by a counter write, kept even while the timer clock
    // is stopped, and spent on the next timer clock pulse
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            block_q <= 1'b0;
        end else if (count_write_in) begin
            block_q <= 1'b1;
        end else if (tick_in) begin
            block_q <= 1'b0;
        end
    end

endmodule

// *** ocu_checker.sv ***
// Assertion checker for the output compare channel ports
`timescale 1ns/1ns
module ocu_checker
    import ocu_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic                  sys_clk_in,
    input wire logic                  sys_rst_in,
    // Watched inputs
    input wire ocu_cnt_stat_t         cnt_stat_in,
    input wire logic                  count_write_in,
    input wire ocu_cpu_wr_t           cpu_wr_in,
    input wire logic                  read_high_in,
    input wire logic [3:0]            waveform_select_in,
    input wire logic [1:0]            compare_output_action_in,
    input wire logic                  force_compare_strobe_in,
    input wire logic                  compare_irq_enable_in,
    input wire logic                  flag_clear_write_in,
    input wire logic                  irq_ack_in,
    input wire logic                  port_data_in,
    input wire logic                  output_pin_direction_bit_in,
    // Watched outputs
    input wire logic                  compare_match_flag_out,
    input wire logic                  irq_req_out,
    input wire logic                  match_out,
    input wire logic                  compare_output_state_out,
    input wire logic [CNT_W-1:0]      compare_value_reg_out,
    input wire logic [OCU_BYTE_W-1:0] read_data_out,
    input wire logic                  pin_out,
    input wire logic                  pin_oe_out
);
    logic blk_q, pend_q, non_pwm, hit, flag_set;
    logic [7:0] tmp_q;

    // Expected output state after one compare action
    function automatic logic nxt(input logic [1:0] a, input logic s);
        if (a == OCU_ACT_TOGGLE) return !s;
        if (a == OCU_ACT_NONE) return s;
        return a == OCU_ACT_SET;
    endfunction

    // Block lasts from a counter write until a tick, even if ticks stop
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) blk_q <= 1'b0;
        else if (count_write_in) blk_q <= 1'b1;
        else if (cnt_stat_in.tick) blk_q <= 1'b0;
    end
    // A match sets the flag on the following tick, not its own; every tick clears pend_q
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || cnt_stat_in.tick) pend_q <= 1'b0;
        else if (match_out) pend_q <= 1'b1;
    end
    // Shadow of the shared high byte holding register
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) tmp_q <= 8'h00;
        else if (cpu_wr_in.wr_high) tmp_q <= cpu_wr_in.data;
    end
    assign non_pwm = waveform_select_in inside {OCU_WGM_NORMAL,
        OCU_WGM_CTC_A, OCU_WGM_CTC_CAP, OCU_WGM_RESERVED};
    assign hit = cnt_stat_in.tick && !count_write_in && !blk_q &&
                 cnt_stat_in.count == compare_value_reg_out;
    assign flag_set = cnt_stat_in.tick && (pend_q || match_out);

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    match_set_a: assert property (!$past(sys_rst_in) |->
        match_out == $past(hit)) else $error("match pulse mismatch");
    flag_set_a: assert property (flag_set |=>
        compare_match_flag_out) else $error("flag not set");
    flag_cause_a: assert property ($rose(compare_match_flag_out) |->
        $past(flag_set)) else $error("flag set without match");
    flag_clear_a: assert property ((flag_clear_write_in ||
        irq_ack_in && irq_req_out) && !flag_set |=> !compare_match_flag_out)
        else $error("flag not cleared");
    irq_a: assert property (!$past(sys_rst_in) |-> irq_req_out ==
        (compare_match_flag_out && $past(compare_irq_enable_in)))
        else $error("interrupt request mismatch");
    force_act_a: assert property (
        force_compare_strobe_in && non_pwm |=> compare_output_state_out ==
        nxt($past(compare_output_action_in), $past(compare_output_state_out)))
        else $error("forced state wrong");
    state_hold_a: assert property (compare_output_action_in == 2'h0
        |=> $stable(compare_output_state_out)) else $error("state changed");
    pin_mux_a: assert property (!$past(sys_rst_in) |->
        pin_oe_out == $past(output_pin_direction_bit_in) && pin_out ==
        ($past(compare_output_action_in) != 2'h0 ? compare_output_state_out
        : $past(port_data_in))) else $error("pin override wrong");
    cmp_load_a: assert property (cpu_wr_in.wr_low && non_pwm |=>
        compare_value_reg_out == {$past(tmp_q), $past(cpu_wr_in.data)})
        else $error("compare word not loaded");
    cmp_hold_a: assert property (!cpu_wr_in.wr_low &&
        !cnt_stat_in.tick |=> $stable(compare_value_reg_out))
        else $error("compare value changed by itself");
    read_hi_a: assert property (read_high_in && non_pwm |=>
        read_data_out == $past(compare_value_reg_out[15:8]))
        else $error("high byte read wrong");

    // Main scenarios reached
    cover property (match_out);
    cover property (force_compare_strobe_in && non_pwm);
    cover property (flag_clear_write_in && compare_match_flag_out);
    cover property (cnt_stat_in.tick && cnt_stat_in.bottom && !non_pwm);
endmodule

// *** ocu_cpu_model.sv ***
// CPU core model writing 16-bit compare values as two byte writes
`timescale 1ns/1ns
module ocu_cpu_model
    import ocu_pkg::*;
(
    // Clock
    input  wire logic  sys_clk_in,
    // Byte writes towards the compare unit
    output ocu_cpu_wr_t cpu_wr_out
);
    initial cpu_wr_out = '0;

    // Idle gap between bytes models a slow CPU; a released bus shows
    // the inverse of the last byte so stale data cannot pass
    // high byte first
    task automatic write16(input logic [15:0] v, input int gap);
        cpu_wr_out = '{1'b1, 1'b0, v[15:8]};
        @(posedge sys_clk_in);
        #1;
        if (gap > 0) begin
            cpu_wr_out = '{1'b0, 1'b0, ~v[15:8]};
            repeat (gap) @(posedge sys_clk_in);
            #1;
        end
        cpu_wr_out = '{1'b0, 1'b1, v[7:0]};
        @(posedge sys_clk_in);
        #1;
        cpu_wr_out = '{1'b0, 1'b0, ~v[7:0]};
    endtask
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the output compare channel
`timescale 1ns/1ns
module tb_top;
    import ocu_pkg::*;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    ocu_cnt_stat_t cs  = '0;
    logic          cw  = 1'b0, rh = 1'b0, frc = 1'b0, ien = 1'b1;
    logic          clr = 1'b0, ack = 1'b0, pd = 1'b0, dir = 1'b0;
    logic [3:0]    wgm = OCU_WGM_NORMAL;
    logic [1:0]    act = OCU_ACT_NONE;
    ocu_cpu_wr_t   wr;
    logic          flag, irq, mat, st, pin, oe;
    logic [15:0]   cmp;
    logic [7:0]    rd;
    logic [1:0]    acts [4] = '{2'h2, 2'h1, 2'h1, 2'h3};
    logic          ex_st [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int            num_errors = 0;
    int            tests_run = 0;

    // Free running system clock
    always #10 clk = ~clk;

    ocu_compare_unit i_dut (
        .sys_clk_in(clk), .sys_rst_in(rst), .cnt_stat_in(cs),
        .count_write_in(cw), .cpu_wr_in(wr), .read_high_in(rh),
        .waveform_select_in(wgm), .compare_output_action_in(act),
        .force_compare_strobe_in(frc), .compare_irq_enable_in(ien),
        .flag_clear_write_in(clr), .irq_ack_in(ack), .port_data_in(pd),
        .output_pin_direction_bit_in(dir), .compare_match_flag_out(flag),
        .irq_req_out(irq), .match_out(mat), .compare_output_state_out(st),
        .compare_value_reg_out(cmp), .read_data_out(rd), .pin_out(pin),
        .pin_oe_out(oe));
    ocu_cpu_model i_cpu (.sys_clk_in(clk), .cpu_wr_out(wr));

    // Inputs always change 1 ns after the rising edge
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One timer clock pulse carrying a count value
    task automatic tick(input logic [15:0] c, input logic t = 1'b0,
                        input logic b = 1'b0);
        cs = '{1'b1, t, b, c};
        step();
        cs.tick = 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        step(12);
        rst = 1'b0;
        step();
        check("state", 0, st);
        i_cpu.write16(16'h1234, 0);
        check("cmp", 16'h1234, cmp);
        rh = 1'b1;
        step();
        check("read hi", 8'h12, rd);
        rh = 1'b0;
        act = OCU_ACT_SET;
        tick(16'h1234);
        check("match", 1, mat);
        check("early flag", 0, flag);
        tick(16'h0001);
        check("flag", 1, flag);
        step();
        check("irq", 1, irq);
        check("set state", 1, st);
        clr = 1'b1;
        step();
        clr = 1'b0;
        check("flag cleared", 0, flag);
        tick(16'h1234);
        tick(16'h0000);
        step();
        ack = 1'b1;
        step();
        ack = 1'b0;
        check("flag acked", 0, flag);
        // Forced actions in Normal and OCU_WGM_CTC_A modes, taking effect at once
        frc = 1'b1;
        for (int i = 0; i < 4; i++) begin
            act = acts[i];
            wgm = i[0] ? OCU_WGM_CTC_A : OCU_WGM_NORMAL;
            step();
            check("forced", ex_st[i], st);
        end
        frc = 1'b0;
        check("no force flag", 0, flag);
        act = OCU_ACT_NONE;
        tick(16'h1234);
        step(2);
        check("none state", 1, st);
        // Counter write while the timer clock is stopped
        cw = 1'b1; // count is neither TOP nor BOTTOM
        step();
        cw = 1'b0;
        step(3);
        tick(16'h1234);
        check("blocked", 0, mat);
        tick(16'h1234);
        check("unblocked", 1, mat);
        wgm = OCU_WGM_FAST_A;
        i_cpu.write16(16'h00aa, 2);
        check("buffered", 16'h1234, cmp);
        tick(16'h0050, 1'b1);
        step();
        check("reloaded", 16'h00aa, cmp);
        wgm = OCU_WGM_NORMAL;
        step();
        check("mode hold", 1, st);
        // state set up before driving the pin
        act = OCU_ACT_SET;
        dir = 1'b1;
        step();
        check("pin state", 1, pin);
        check("pin oe", 1, oe);
        act = OCU_ACT_NONE;
        dir = 1'b0;
        step();
        check("pin port", 0, pin);
        check("pin off", 0, oe);
        // Fast PWM, non-inverting: cleared at TOP, set on match
        wgm = OCU_WGM_FAST_A;
        act = OCU_ACT_CLEAR;
        tick(16'h00ff, 1'b1);
        check("pwm top", 0, st);
        tick(16'h00aa);
        check("pwm match", 1, st);
        // Dual slope, phase and frequency correct: reload at BOTTOM only, level follows direction
        wgm = OCU_WGM_PFC_A;
        i_cpu.write16(16'h0010, 0);
        tick(16'h00ff, 1'b1);
        check("no top reload", 16'h00aa, cmp);
        tick(16'h0000, 1'b0, 1'b1);
        check("bottom reload", 16'h0010, cmp);
        tick(16'h0010);
        check("up match", 0, st);
        tick(16'h00ff, 1'b1);
        tick(16'h0010);
        check("down match", 1, st);
        stop_test();
    end

    // Hang guard at 2000 cycles, far beyond the roughly 55 cycles the tests need
    initial begin
        #40000;
        num_errors++;
        stop_test();
    end
endmodule

bind ocu_compare_unit ocu_checker #(.CNT_W(CNT_W)) i_chk (.*);
